// ===== pcfg_consts.vh
// constants for the pin 3..6 configuration block
// assumes a 125 MHz reference clock and 8-bit registers
`ifndef PCFG_CONSTS_VH
`define PCFG_CONSTS_VH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define PCFG_ADDR_PIN3    8'h73
`define PCFG_ADDR_PIN4    8'h74
`define PCFG_ADDR_PIN5    8'h75
`define PCFG_ADDR_PIN6    8'h76
`define PCFG_ADDR_PULLUP  8'h78
`define PCFG_ADDR_PULLDN  8'h79

// ----------------------------------------
// field positions and reset values
// ----------------------------------------
`define PCFG_DBNC_MSB     7
`define PCFG_DBNC_LSB     6
`define PCFG_EDGE_MSB     5
`define PCFG_EDGE_LSB     4
`define PCFG_BIT_OUT      3
`define PCFG_BIT_IN       2
`define PCFG_BIT_DIR      1
`define PCFG_BIT_DRV      0
`define PCFG_PULL_LSB     3
`define PCFG_CFG_RESET    8'h00
`define PCFG_PULL_RESET   1'h0

// ----------------------------------------
// field codes
// ----------------------------------------
`define PCFG_DBNC_NONE    2'h0
`define PCFG_DBNC_8MS     2'h1
`define PCFG_DBNC_16MS    2'h2
`define PCFG_DBNC_32MS    2'h3
`define PCFG_EDGE_FALL    0
`define PCFG_EDGE_RISE    1

// ----------------------------------------
// timing
// ----------------------------------------
`define PCFG_CLK_KHZ      125000
`define PCFG_T8_MS        8
`define PCFG_T16_MS       16
`define PCFG_T32_MS       32
`define PCFG_CYC_8MS      (`PCFG_CLK_KHZ * `PCFG_T8_MS)
`define PCFG_CYC_16MS     (`PCFG_CLK_KHZ * `PCFG_T16_MS)
`define PCFG_CYC_32MS     (`PCFG_CLK_KHZ * `PCFG_T32_MS)
`define PCFG_CNT_W        22

`endif

// ===== pcfg_debounce.v
// debounce filter for one synchronised pin level
// assumes level_i is already in the ref_clk_i domain
`timescale 1ns/100ps
`include "pcfg_consts.vh"

module pcfg_debounce #(
    parameter            CNT_W = `PCFG_CNT_W,
    parameter [CNT_W-1:0] CYC8  = `PCFG_CYC_8MS,
    parameter [CNT_W-1:0] CYC16 = `PCFG_CYC_16MS,
    parameter [CNT_W-1:0] CYC32 = `PCFG_CYC_32MS
) (
    // clock and reset
    input  wire       ref_clk_i,
    input  wire       rst_i,
    // level in, selection
    input  wire       level_i,
    input  wire [1:0] sel_i,
    // filtered level
    output reg        level_o
);

    reg  [CNT_W-1:0] cnt_q;
    reg  [CNT_W-1:0] limit;

    always @* begin
        case (sel_i)
            `PCFG_DBNC_8MS:  limit = CYC8;
            `PCFG_DBNC_16MS: limit = CYC16;
            `PCFG_DBNC_32MS: limit = CYC32;
            default:         limit = {CNT_W{1'b0}};
        endcase
    end

    // ----------------------------------------
    // stability counter
    // ----------------------------------------
    // a level change is taken only after limit stable cycles
    always @(posedge ref_clk_i) begin
        if (rst_i) begin
            cnt_q   <= {CNT_W{1'b0}};
            level_o <= 1'b0;
        end else if (sel_i == `PCFG_DBNC_NONE) begin
            cnt_q   <= {CNT_W{1'b0}};
            level_o <= level_i;
        end else if (level_i == level_o) begin
            // any bounce back restarts the wait
            cnt_q   <= {CNT_W{1'b0}};
        end else if (cnt_q >= limit - 1'b1) begin
            cnt_q   <= {CNT_W{1'b0}};
            level_o <= level_i;
        end else begin
            cnt_q   <= cnt_q + 1'b1;
        end
    end

endmodule

// ===== pcfg_pin_load.sv
// pin load model: external source, pull resistors, floating pins
// assumes the device's own drive wins over the external source
`timescale 1ns/100ps
module pcfg_pin_load (
    // device side
    input  wire [3:0] pin_o_i,
    input  wire [3:0] oe_n_i,
    input  wire [3:0] pu_i,
    input  wire [3:0] pd_i,
    // external source
    input  wire [3:0] ext_en_i,
    input  wire [3:0] ext_val_i,
    // resolved level
    output wire [3:0] level_o
);
    // undriven and unpulled pins show the inverse of pin_o, never a stale copy
    assign level_o = (~oe_n_i & pin_o_i) | (oe_n_i & ext_en_i & ext_val_i)
                   | (oe_n_i & ~ext_en_i & (pu_i | (~pd_i & ~pin_o_i)));
endmodule

// ===== pcfg_pins.v
// configuration, drive, sampling and edge events of pins 3 to 6
// assumes a byte register port from the serial front end and
// alternate-mode enables held in a register outside this block
//
// Operation
// - input pins filter both edges; code 00 none, else 8, 16 or 32 ms
// - output pins ignore the debounce selection
// - input edge code 01 falling, 10 rising, 11 both raise a request
// - edge code 00 raises no request
// - output pins ignore the edge selection
// - output level 0 drives low; 1 drives high or releases pin
// - drive type 0 is open-drain, 1 is push-pull
// - input mode, writing output level 0 clears it, sets pull-up
// - input mode, writing output level 1 sets it, sets pull-down
// - input mode, input level bit shows the pin level
// - input mode, input level bit is read-only, writes dropped
// - output mode, input level bit has no effect
// - without alternate mode, direction 0 is output, 1 is input
// - pins 3 and 4 alternate output driven active-high, direction written 0
// - pins 5 and 6 alternate input: direction 0 active-low, 1 active-high
// - input pins ignore the drive type bit
// - each pin has a pull-up enable, 1 connects it
// - each pin has a pull-down enable, 1 connects it
`timescale 1ns/100ps
`include "pcfg_consts.vh"

module pcfg_pins #(
    parameter NPIN  = 4,
    parameter CNT_W = `PCFG_CNT_W,
    parameter [CNT_W-1:0] DBNC8_CYC  = `PCFG_CYC_8MS,
    parameter [CNT_W-1:0] DBNC16_CYC = `PCFG_CYC_16MS,
    parameter [CNT_W-1:0] DBNC32_CYC = `PCFG_CYC_32MS
) (
    // clock and reset
    input  wire            ref_clk_i,
    input  wire            rst_i,

    // register port
    input  wire [7:0]      reg_addr_i,
    input  wire [7:0]      reg_wdata_i,
    input  wire            reg_wr_i,
    input  wire            reg_rd_i,
    output reg  [7:0]      reg_rdata_o,

    // alternate mode
    input  wire [NPIN-1:0] alt_enable_i,
    input  wire [1:0]      alt_out_i,
    output reg  [1:0]      alt_in_o,

    // pins
    input  wire [NPIN-1:0] pin_i,
    output wire [NPIN-1:0] pin_o,
    output wire [NPIN-1:0] pin_oe_n_o,
    output wire [NPIN-1:0] pull_up_o,
    output wire [NPIN-1:0] pull_down_o,

    // pending edge events
    input  wire [NPIN-1:0] irq_clr_i,
    output wire [NPIN-1:0] irq_pend_o,
    output reg             irq_o
);

    // ----------------------------------------
    // address decode
    // ----------------------------------------
    function cfg_hit;
        input [7:0] addr;
        input integer k;
        begin
            cfg_hit = (addr == `PCFG_ADDR_PIN3 + k[7:0]);
        end
    endfunction

    wire [8*NPIN-1:0] cfg_w;
    wire [NPIN-1:0]   in_mode_w;
    wire [NPIN-1:0]   dbnc_lvl_w;
    wire [NPIN-1:0]   sync_lvl_w;
    wire [NPIN-1:0]   pend_w;

    wire wr_pullup = reg_wr_i && (reg_addr_i == `PCFG_ADDR_PULLUP);
    wire wr_pulldn = reg_wr_i && (reg_addr_i == `PCFG_ADDR_PULLDN);

    genvar k;
    generate
        for (k = 0; k < NPIN; k = k + 1) begin : g_pin

            // ----------------------------------------
            // per-pin state
            // ----------------------------------------
            reg [1:0] dbnc_q;
            reg [1:0] edge_q;
            reg       out_q;
            reg       in_q;
            reg       dir_q;
            reg       drv_q;
            reg       pu_q;
            reg       pd_q;
            reg       s1_q;
            reg       s2_q;
            reg       prev_q;
            reg       pend_q;
            reg       pin_q;
            reg       oe_n_q;
            wire      lvl;
            wire      hit;
            wire      is_in;
            wire      rise;
            wire      fall;
            wire      alt_drive;
            wire      val;

            assign hit = reg_wr_i && cfg_hit(reg_addr_i, k);

            // first two pins have an alternate output, the rest an input
            assign alt_drive = (k < 2) && alt_enable_i[k];

            // alternate input pins sample regardless of direction
            assign is_in = alt_enable_i[k] ? (k >= 2) : dir_q;

            // ----------------------------------------
            // configuration writes
            // ----------------------------------------
            always @(posedge ref_clk_i) begin
                if (rst_i) begin
                    dbnc_q <= `PCFG_DBNC_NONE;
                    edge_q <= 2'h0;
                    out_q  <= 1'b0;
                    dir_q  <= 1'b0;
                    drv_q  <= 1'b0;
                end else if (hit) begin
                    dbnc_q <= reg_wdata_i[`PCFG_DBNC_MSB:`PCFG_DBNC_LSB];
                    edge_q <= reg_wdata_i[`PCFG_EDGE_MSB:`PCFG_EDGE_LSB];
                    out_q  <= reg_wdata_i[`PCFG_BIT_OUT];
                    dir_q  <= reg_wdata_i[`PCFG_BIT_DIR];
                    drv_q  <= reg_wdata_i[`PCFG_BIT_DRV];
                end
            end

            // input level: follows the pin while an input
            always @(posedge ref_clk_i) begin
                if (rst_i) begin
                    in_q <= 1'b0;
                end else if (is_in) begin
                    in_q <= lvl;
                end else if (hit) begin
                    // stored only, never steers anything
                    in_q <= reg_wdata_i[`PCFG_BIT_IN];
                end
            end

            // ----------------------------------------
            // pull enables
            // ----------------------------------------
            // the output-level write in input mode only sets, never clears
            always @(posedge ref_clk_i) begin
                if (rst_i) begin
                    pu_q <= `PCFG_PULL_RESET;
                    pd_q <= `PCFG_PULL_RESET;
                end else begin
                    if (wr_pullup) begin
                        pu_q <= reg_wdata_i[`PCFG_PULL_LSB + k];
                    end else if (hit && is_in && !reg_wdata_i[`PCFG_BIT_OUT]) begin
                        pu_q <= 1'b1;
                    end
                    if (wr_pulldn) begin
                        pd_q <= reg_wdata_i[`PCFG_PULL_LSB + k];
                    end else if (hit && is_in && reg_wdata_i[`PCFG_BIT_OUT]) begin
                        pd_q <= 1'b1;
                    end
                end
            end

            // ----------------------------------------
            // input path
            // ----------------------------------------
            always @(posedge ref_clk_i) begin
                if (rst_i) begin
                    s1_q <= 1'b0;
                    s2_q <= 1'b0;
                end else begin
                    s1_q <= pin_i[k];
                    s2_q <= s1_q;
                end
            end

            // filter bypassed on outputs so the selection has no effect
            pcfg_debounce #(
                .CNT_W (CNT_W),
                .CYC8  (DBNC8_CYC),
                .CYC16 (DBNC16_CYC),
                .CYC32 (DBNC32_CYC)
            ) u_dbnc (
                .ref_clk_i (ref_clk_i),
                .rst_i     (rst_i),
                .level_i   (s2_q),
                .sel_i     (is_in ? dbnc_q : `PCFG_DBNC_NONE),
                .level_o   (lvl)
            );

            // ----------------------------------------
            // edge events
            // ----------------------------------------
            assign rise = lvl && !prev_q;
            assign fall = !lvl && prev_q;

            always @(posedge ref_clk_i) begin
                if (rst_i) begin
                    prev_q <= 1'b0;
                    pend_q <= 1'b0;
                end else begin
                    prev_q <= lvl;
                    // a new edge wins over a clear in the same cycle
                    if (is_in && ((fall && edge_q[`PCFG_EDGE_FALL]) ||
                                  (rise && edge_q[`PCFG_EDGE_RISE]))) begin
                        pend_q <= 1'b1;
                    end else if (irq_clr_i[k]) begin
                        pend_q <= 1'b0;
                    end
                end
            end

            // ----------------------------------------
            // output drive
            // ----------------------------------------
            assign val = alt_drive ? alt_out_i[k] : out_q;

            always @(posedge ref_clk_i) begin
                if (rst_i) begin
                    pin_q  <= 1'b0;
                    oe_n_q <= 1'b1;
                end else if (is_in) begin
                    pin_q  <= 1'b0;
                    oe_n_q <= 1'b1;
                end else if (!val) begin
                    pin_q  <= 1'b0;
                    oe_n_q <= 1'b0;
                end else begin
                    // high level: push-pull drives, open-drain lets go
                    pin_q  <= drv_q;
                    oe_n_q <= !drv_q;
                end
            end

            assign pin_o[k]      = pin_q;
            assign pin_oe_n_o[k] = oe_n_q;

            assign cfg_w[8*k +: 8] = {dbnc_q, edge_q, out_q, in_q, dir_q, drv_q};
            assign in_mode_w[k]    = is_in;
            assign dbnc_lvl_w[k]   = lvl;
            assign sync_lvl_w[k]   = s2_q;
            assign pend_w[k]       = pend_q;
            assign pull_up_o[k]    = pu_q;
            assign pull_down_o[k]  = pd_q;
        end
    endgenerate

    assign irq_pend_o = pend_w;

    // ----------------------------------------
    // alternate inputs and interrupt
    // ----------------------------------------
    // polarity folded here so the consumer always sees active-high
    always @(posedge ref_clk_i) begin
        if (rst_i) begin
            alt_in_o <= 2'h0;
            irq_o    <= 1'b0;
        end else begin
            alt_in_o[0] <= alt_enable_i[2] &&
                           (cfg_w[16+`PCFG_BIT_DIR] ? dbnc_lvl_w[2] : !dbnc_lvl_w[2]);
            alt_in_o[1] <= alt_enable_i[3] &&
                           (cfg_w[24+`PCFG_BIT_DIR] ? dbnc_lvl_w[3] : !dbnc_lvl_w[3]);
            irq_o       <= |pend_w;
        end
    end

    // ----------------------------------------
    // read port
    // ----------------------------------------
    reg [7:0] rd_d;
    integer   i;

    always @* begin
        rd_d = 8'h00;
        for (i = 0; i < NPIN; i = i + 1) begin
            if (cfg_hit(reg_addr_i, i)) begin
                rd_d = cfg_w[8*i +: 8];
            end
        end
        if (reg_addr_i == `PCFG_ADDR_PULLUP) begin
            rd_d = {1'b0, pull_up_o, 3'h0};
        end else if (reg_addr_i == `PCFG_ADDR_PULLDN) begin
            rd_d = {1'b0, pull_down_o, 3'h0};
        end
    end

    // one cycle read latency; other offsets read as zero
    always @(posedge ref_clk_i) begin
        if (rst_i) begin
            reg_rdata_o <= 8'h00;
        end else if (reg_rd_i) begin
            reg_rdata_o <= rd_d;
        end
    end

endmodule

// ===== pcfg_pins_asserts.sv
// assertions on the ports of pcfg_pins
// bound into every instance of that module
`timescale 1ns/100ps
module pcfg_pins_asserts #(
    parameter NPIN = 4
) (
    // watched ports
    input wire            ref_clk_i,
    input wire            rst_i,
    input wire [7:0]      reg_addr_i,
    input wire [7:0]      reg_wdata_i,
    input wire            reg_wr_i,
    input wire            reg_rd_i,
    input wire [7:0]      reg_rdata_o,
    input wire [NPIN-1:0] alt_enable_i,
    input wire [1:0]      alt_in_o,
    input wire [NPIN-1:0] pin_o,
    input wire [NPIN-1:0] pin_oe_n_o,
    input wire [NPIN-1:0] pull_up_o,
    input wire [NPIN-1:0] pull_down_o,
    input wire [NPIN-1:0] irq_clr_i,
    input wire [NPIN-1:0] irq_pend_o,
    input wire            irq_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);
    a_irq_follows_flags: assert property (irq_o == |$past(irq_pend_o))
        else $error("irq out differs from flags");
    a_flag_held: assert property (&(~$past(irq_pend_o) | $past(irq_clr_i) | irq_pend_o))
        else $error("flag dropped without clear");
    a_push_drive_high: assert property (reg_wr_i && reg_addr_i == 8'h73
        && reg_wdata_i[3:0] == 4'h9 && !alt_enable_i[0] |-> ##2 pin_o[0] && !pin_oe_n_o[0])
        else $error("push-pull high not driven");
    a_drain_release: assert property (reg_wr_i && reg_addr_i == 8'h73
        && reg_wdata_i[3:0] == 4'h8 && !alt_enable_i[0] |-> ##2 pin_oe_n_o[0])
        else $error("open-drain high not released");
    a_unmapped_zero: assert property (reg_rd_i && reg_addr_i == 8'h7A |=> reg_rdata_o == 8'h00)
        else $error("unmapped read not zero");
    a_rdata_holds: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
        else $error("read data moved without read");
    a_pullup_write: assert property (reg_wr_i && reg_addr_i == 8'h78
        && reg_wdata_i[3] |-> ##[1:2] pull_up_o[0]) else $error("pull-up not set");
    a_pulldown_write: assert property (reg_wr_i && reg_addr_i == 8'h79
        && reg_wdata_i[4] |-> ##[1:2] pull_down_o[1]) else $error("pull-down not set");
    a_alt_in_idle: assert property (!alt_enable_i[2] |=> !alt_in_o[0])
        else $error("alternate input active while disabled");
endmodule

bind pcfg_pins pcfg_pins_asserts #(.NPIN(NPIN)) pcfg_pins_asserts_i (
    .ref_clk_i, .rst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
    .alt_enable_i, .alt_in_o, .pin_o, .pin_oe_n_o, .pull_up_o, .pull_down_o, .irq_clr_i,
    .irq_pend_o, .irq_o);

// ===== tb_pcfg_pins.sv
// testbench for the pin 3..6 configuration block
// assumes debounce counts cut to 8, 16 and 32 cycles
`timescale 1ns/100ps
module tb_pcfg_pins;
    reg        clk = 1'b0;
    reg        rst = 1'b1;
    reg        wr = 1'b0;
    reg        rd = 1'b0;
    reg  [7:0] addr = 8'h00;
    reg  [7:0] wdata = 8'h00;
    reg  [3:0] alt_en = 4'h0;
    reg  [1:0] alt_out = 2'h0;
    reg  [3:0] clr = 4'h0;
    reg  [3:0] ext_en = 4'h0;
    reg  [3:0] ext_val = 4'h0;
    wire [7:0] rdata;
    wire [1:0] alt_in;
    wire [3:0] pin_o, oe_n, pu, pd, pend, lvl;
    wire       irq;
    integer    mismatches = 0;
    integer    n_compared = 0;
    reg  [7:0] k;
    integer    lim;

    pcfg_pins #(.DBNC8_CYC(22'h8), .DBNC16_CYC(22'h10), .DBNC32_CYC(22'h20)) pcfg_pins_i (
        .ref_clk_i(clk), .rst_i(rst), .reg_addr_i(addr), .reg_wdata_i(wdata),
        .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .alt_enable_i(alt_en),
        .alt_out_i(alt_out), .alt_in_o(alt_in), .pin_i(lvl), .pin_o(pin_o),
        .pin_oe_n_o(oe_n), .pull_up_o(pu), .pull_down_o(pd), .irq_clr_i(clr),
        .irq_pend_o(pend), .irq_o(irq));
    pcfg_pin_load pcfg_pin_load_i (.pin_o_i(pin_o), .oe_n_i(oe_n), .pu_i(pu), .pd_i(pd),
        .ext_en_i(ext_en), .ext_val_i(ext_val), .level_o(lvl));

    initial begin
        forever #4 clk = ~clk;
    end
    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task cyc(input integer n);
        repeat (n) @(negedge clk);
    endtask
    task chk(input [7:0] seen, input [7:0] exp);
        begin
            n_compared = n_compared + 1;
            if (seen !== exp) begin
                mismatches = mismatches + 1;
                $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
            end
        end
    endtask
    task wrb(input [7:0] a, input [7:0] d);
        begin
            @(negedge clk);
            addr = a;
            wdata = d;
            wr = 1'b1;
            @(negedge clk);
            wr = 1'b0;
        end
    endtask
    task rdc(input [7:0] a, input [7:0] e);
        begin
            @(negedge clk);
            addr = a;
            rd = 1'b1;
            @(negedge clk);
            rd = 1'b0;
            chk(rdata, e);
        end
    endtask
    task pclr;
        begin
            @(negedge clk);
            clr = 4'hF;
            @(negedge clk);
            clr = 4'h0;
        end
    endtask
    task give_verdict;
        begin
            $display("compared %0d mismatched %0d", n_compared, mismatches);
            if (mismatches == 0 && n_compared > 0)
                $display("ALL TESTS PASSED");
            else
                $display("TESTS FAILED");
            $finish;
        end
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task t_out;
        for (k = 0; k < 4; k = k + 1) begin
            rdc(8'h73 + k, 8'h00);
            chk({pin_o[k], oe_n[k]}, 2'b00);
            wrb(8'h73 + k, 8'hC9);
            cyc(3);
            chk({pin_o[k], oe_n[k]}, 2'b10);
            cyc(8);
            rdc(8'h73 + k, 8'hC9);
            wrb(8'h73 + k, 8'h08);
            cyc(3);
            chk(oe_n[k], 1'b1);
            wrb(8'h73 + k, 8'hF5);
            // long enough for a falling edge to reach the flag if it were taken
            cyc(6);
            chk({pin_o[k], oe_n[k], pend[k]}, 3'b000);
        end
    endtask
    task t_in;
        begin
            ext_en[3] = 1'b1;
            wrb(8'h76, 8'h22);
            wrb(8'h76, 8'h2A);
            cyc(3);
            chk(pd[3], 1'b1);
            rdc(8'h76, 8'h2A);
            wrb(8'h76, 8'h27);
            cyc(3);
            chk({pu[3], oe_n[3]}, 2'b11);
            rdc(8'h76, 8'h23);
            pclr;
            ext_val[3] = 1'b1;
            cyc(8);
            chk({irq, pend[3]}, 2'b11);
            rdc(8'h76, 8'h27);
            pclr;
            cyc(2);
            chk({irq, pend[3]}, 2'b00);
            ext_val[3] = 1'b0;
            cyc(8);
            chk(pend[3], 1'b0);
        end
    endtask
    task t_edges;
        for (k = 0; k < 4; k = k + 1) begin
            wrb(8'h75, {2'b00, k[1:0], 4'h2});
            ext_en[2] = 1'b1;
            cyc(8);
            pclr;
            ext_val[2] = 1'b1;
            cyc(8);
            chk(pend[2], k[1]);
            pclr;
            ext_val[2] = 1'b0;
            cyc(8);
            chk(pend[2], k[0]);
            pclr;
        end
    endtask
    task t_dbnc;
        for (k = 1; k < 4; k = k + 1) begin
            lim = 8 << (k - 1);
            wrb(8'h73, {k[1:0], 6'h32});
            ext_en[0] = 1'b1;
            cyc(lim + 8);
            pclr;
            // a glitch just under the window must not get through
            ext_val[0] = 1'b1;
            cyc(lim - 2);
            ext_val[0] = 1'b0;
            cyc(lim + 8);
            chk(pend[0], 1'b0);
            ext_val[0] = 1'b1;
            cyc(lim - 2);
            chk(pend[0], 1'b0);
            cyc(8);
            chk(pend[0], 1'b1);
            ext_val[0] = 1'b0;
            cyc(lim + 8);
            pclr;
        end
    endtask
    task t_alt;
        begin
            wrb(8'h73, 8'h01);
            ext_en[0] = 1'b0;
            alt_en = 4'h5;
            alt_out = 2'h1;
            cyc(4);
            chk({pin_o[0], oe_n[0]}, 2'b10);
            alt_out = 2'h0;
            wrb(8'h75, 8'h00);
            cyc(8);
            chk({pin_o[0], alt_in[0]}, 2'b01);
            wrb(8'h75, 8'h02);
            cyc(8);
            chk(alt_in[0], 1'b0);
            ext_val[2] = 1'b1;
            cyc(8);
            chk(alt_in[0], 1'b1);
            alt_en = 4'hA;
            alt_out = 2'h2;
            ext_val[3] = 1'b1;
            cyc(8);
            chk({pin_o[1], oe_n[1], alt_in[1]}, 3'b101);
            alt_en = 4'h0;
            cyc(3);
            chk(alt_in, 2'h0);
        end
    endtask
    task t_pulls;
        begin
            wrb(8'h78, 8'hFF);
            wrb(8'h79, 8'h10);
            cyc(3);
            chk({pu, pd}, 8'hF2);
            rdc(8'h78, 8'h78);
            rdc(8'h79, 8'h10);
            rdc(8'h7A, 8'h00);
            wrb(8'h78, 8'h00);
            cyc(3);
            chk(pu, 8'h00);
        end
    endtask

    initial begin
        repeat (20) @(negedge clk);
        rst = 1'b0;
        t_out;
        $display("output test done");
        t_in;
        $display("input test done");
        t_edges;
        $display("edge test done");
        t_dbnc;
        $display("debounce test done");
        t_alt;
        $display("alternate test done");
        t_pulls;
        $display("pull test done");
        give_verdict;
    end
    initial begin
        #400000;
        mismatches = mismatches + 1;
        give_verdict;
    end
endmodule
